// [src/pmmb_cfg.svh]
// program memory and mode bus: shared constants
// assumes inclusion by bare name from the design files
`ifndef PMMB_CFG_SVH
`define PMMB_CFG_SVH
`define PMMB_RESET_VEC    16'h0000
`define PMMB_VEC_INT      16'h0008
`define PMMB_VEC_TMR      16'h0010
`define PMMB_VEC_TCK      16'h0018
`define PMMB_VEC_PER      16'h0020
`define PMMB_CFG_UNPROG   2'h3
`define PMMB_CFG_MPU      2'h3
`define PMMB_CFG_MCU      2'h2
`define PMMB_CFG_EXT      2'h1
`define PMMB_CFG_PROT     2'h0
`define PMMB_INT_WORDS    17'h02000
`define PMMB_SPECIAL_BASE 16'hFE00
`define PMMB_SAVE_LO      8'h18
`define PMMB_SAVE_HI      8'h1F
`define PMMB_STACK_DEPTH  16
`define PMMB_PHASES       4
`endif

// [src/pmmb_core.sv]
// program memory and mode bus: fetch steering, modes and vectoring
// assumes internal memory answers combinationally; fetches are one at a time
`timescale 1ns/10ps
`include "pmmb_cfg.svh"
module pmmb_core #(
    parameter int STACK_DEPTH = `PMMB_STACK_DEPTH,
    parameter logic [16:0] INT_WORDS = `PMMB_INT_WORDS
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // configuration and sequencing
    input  wire logic [1:0]  cfgBits,
    input  wire logic        fetchReq,
    input  wire logic        jumpReq,
    input  wire logic [15:0] jumpAddr,
    input  wire logic        intReq,
    input  wire logic [1:0]  intSel,
    input  wire logic        returnReq,
    // fetch result
    output logic [15:0]      progCounter,
    output logic [15:0]      instrWord,
    output logic             instrValid,
    output logic             codeProtect,
    output logic             specialAccess,
    output logic             externalMode,
    // internal program memory
    output logic [15:0]      intMemAddr,
    input  wire logic [15:0] intMemData,
    // data memory path, always on chip
    input  wire logic        dataWe,
    input  wire logic [7:0]  dataAddr,
    input  wire logic [7:0]  dataWdata,
    output logic [7:0]       dataRdata,
    // shared lines and strobes
    input  wire logic [15:0] adIn,
    output logic [15:0]      adOut,
    output logic             adOe,
    output logic             addrLatchStrobe,
    output logic             readStrobe_n,
    output logic             writeStrobe_n
);
    pmmb_pkg::pmmb_mode_e mode;
    logic [15:0] pc_q;
    logic [15:0] stack_q [STACK_DEPTH];
    logic [3:0]  sp_q;
    logic [7:0]  dataMem [256];
    logic        inInternal;
    logic        goExternal;
    logic        extStart;
    logic        extBusy;
    logic        extDone;
    logic [15:0] extData;
    logic        pending_q;
    logic        pendingExt_q;
    logic [15:0] vector;

    ////////////////////////////////////////////////////////////////////////
    // mode decode; unprogrammed bits read as microprocessor
    always_comb begin
        case (cfgBits)
            `PMMB_CFG_MPU:  mode = pmmb_pkg::PMMB_MPU;
            `PMMB_CFG_MCU:  mode = pmmb_pkg::PMMB_MCU;
            `PMMB_CFG_EXT:  mode = pmmb_pkg::PMMB_EXT;
            `PMMB_CFG_PROT: mode = pmmb_pkg::PMMB_PROT;
            default:        mode = pmmb_pkg::PMMB_MPU;
        endcase
    end

    assign codeProtect   = (mode == pmmb_pkg::PMMB_PROT);
    assign specialAccess = (mode == pmmb_pkg::PMMB_MCU) || (mode == pmmb_pkg::PMMB_PROT)
                         ? (pc_q >= `PMMB_SPECIAL_BASE) : 1'b0;
    assign externalMode  = (mode == pmmb_pkg::PMMB_MPU) || (mode == pmmb_pkg::PMMB_EXT);
    assign inInternal    = ({1'b0, pc_q} < INT_WORDS);
    assign goExternal    = (mode == pmmb_pkg::PMMB_MPU) || ((mode == pmmb_pkg::PMMB_EXT) && !inInternal);
    assign intMemAddr    = pc_q;
    assign progCounter   = pc_q;

    always_comb begin
        case (intSel)
            2'h0:    vector = `PMMB_VEC_INT;
            2'h1:    vector = `PMMB_VEC_TMR;
            2'h2:    vector = `PMMB_VEC_TCK;
            default: vector = `PMMB_VEC_PER;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // fetch issue: external modes always run a bus cycle, so strobes
    // mirror internal fetches too in extended mode
    assign extStart = fetchReq && !pending_q && externalMode;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pending_q    <= 1'b0;
            pendingExt_q <= 1'b0;
            instrValid   <= 1'b0;
            instrWord    <= 16'h0000;
        end else begin
            instrValid <= 1'b0;
            if (fetchReq && !pending_q && !externalMode) begin
                // outside internal memory the word is undefined; mux returns whatever is there
                instrWord  <= intMemData;
                instrValid <= 1'b1;
            end else if (extStart) begin
                pending_q    <= 1'b1;
                pendingExt_q <= goExternal;
                if (!goExternal) begin
                    instrWord <= intMemData;
                end
            end else if (pending_q && extDone) begin
                pending_q  <= 1'b0;
                instrValid <= 1'b1;
                if (pendingExt_q) begin
                    instrWord <= extData;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter and return stack: only the counter is saved
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pc_q <= `PMMB_RESET_VEC;
            sp_q <= 4'h0;
        end else if (intReq) begin
            stack_q[sp_q] <= pc_q;
            sp_q          <= sp_q + 4'h1;
            pc_q          <= vector;
        end else if (returnReq) begin
            sp_q <= sp_q - 4'h1;
            pc_q <= stack_q[sp_q - 4'h1];
        end else if (jumpReq) begin
            pc_q <= jumpAddr;
        end else if (instrValid) begin
            pc_q <= pc_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory on its own path; never touches the bus
    // flag-free byte moves (save area 18h-1Fh) are plain writes here
    always_ff @(posedge clk_sys) begin
        if (dataWe) begin
            dataMem[dataAddr] <= dataWdata;
        end
    end
    assign dataRdata = dataMem[dataAddr];

    pmmb_ext_bus u_bus (
        .clk_sys         (clk_sys),
        .reset_n         (reset_n),
        .start           (extStart),
        .addr            (pc_q),
        .busy            (extBusy),
        .done            (extDone),
        .rdata           (extData),
        .adIn            (adIn),
        .adOut           (adOut),
        .adOe            (adOe),
        .addrLatchStrobe (addrLatchStrobe),
        .readStrobe_n    (readStrobe_n),
        .writeStrobe_n   (writeStrobe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence s_addr_phase;
        addrLatchStrobe && adOe;
    endsequence
    sequence s_read_phase;
        !adOe && !readStrobe_n;
    endsequence

    a_reset_vector: assert property (@(posedge clk_sys) $rose(reset_n) |-> pc_q == `PMMB_RESET_VEC)
        else $error("pc not zero after reset");
    a_bus_seq: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_addr_phase |=> s_read_phase) else $error("read phase missing");
    a_mcu_no_bus: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !externalMode |-> !adOe && !addrLatchStrobe) else $error("bus used in internal mode");
    a_prot_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
        codeProtect == (cfgBits == `PMMB_CFG_PROT)) else $error("protection mismatch");
    a_ext_done: assert property (@(posedge clk_sys) disable iff (!reset_n)
        extStart |-> ##4 instrValid) else $error("external fetch late");
    a_mpu_all_ext: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (fetchReq && !pending_q && cfgBits == `PMMB_CFG_MPU) |=> addrLatchStrobe)
        else $error("mpu fetch not external");
    a_int_vector: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (intReq && intSel == 2'h1) |=> pc_q == `PMMB_VEC_TMR) else $error("wrong vector");
    a_special_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
        externalMode |-> !specialAccess) else $error("special area in external mode");
    // a second bus cycle must never start over one still in flight
    a_one_fetch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        extBusy |-> !extStart) else $error("bus start while busy");
endmodule : pmmb_core

// [src/pmmb_ext_bus.sv]
// program memory and mode bus: multiplexed external bus cycle engine
// assumes a one-cycle start pulse and an outside address latch
`timescale 1ns/10ps
`include "pmmb_cfg.svh"
module pmmb_ext_bus (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // fetch request
    input  wire logic        start,
    input  wire logic [15:0] addr,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rdata,
    // shared lines and strobes
    input  wire logic [15:0] adIn,
    output logic [15:0]      adOut,
    output logic             adOe,
    output logic             addrLatchStrobe,
    output logic             readStrobe_n,
    output logic             writeStrobe_n
);
    pmmb_pkg::pmmb_phase_e phase_q;
    logic                  active_q;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            phase_q  <= pmmb_pkg::PH_ADDR;
            active_q <= 1'b0;
        end else begin
            case (phase_q)
                pmmb_pkg::PH_ADDR: begin
                    if (start) begin
                        active_q <= 1'b1;
                        phase_q  <= pmmb_pkg::PH_TURN;
                    end
                end
                pmmb_pkg::PH_TURN: phase_q <= pmmb_pkg::PH_READ;
                pmmb_pkg::PH_READ: phase_q <= pmmb_pkg::PH_DONE;
                pmmb_pkg::PH_DONE: begin
                    active_q <= 1'b0;
                    phase_q  <= pmmb_pkg::PH_ADDR;
                end
                default: phase_q <= pmmb_pkg::PH_ADDR;
            endcase
        end
    end

    // address phase: drive lines with latch strobe high
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            adOut           <= 16'h0000;
            adOe            <= 1'b0;
            addrLatchStrobe <= 1'b0;
            readStrobe_n    <= 1'b1;
            rdata           <= 16'h0000;
            done            <= 1'b0;
        end else begin
            done            <= 1'b0;
            addrLatchStrobe <= 1'b0;
            if (phase_q == pmmb_pkg::PH_ADDR && start) begin
                adOut           <= addr;
                adOe            <= 1'b1;
                addrLatchStrobe <= 1'b1;
            end
            if (phase_q == pmmb_pkg::PH_TURN) begin
                adOe         <= 1'b0;
                readStrobe_n <= 1'b0;
            end
            if (phase_q == pmmb_pkg::PH_READ) begin
                rdata        <= adIn;
                readStrobe_n <= 1'b1;
                done         <= 1'b1;
            end
        end
    end

    assign busy          = active_q;
    assign writeStrobe_n = 1'b1;

    // lines are never driven while the read strobe is low
    a_no_conflict: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(adOe && !readStrobe_n)) else $error("bus driven during read");
endmodule : pmmb_ext_bus

// [src/pmmb_pkg.sv]
// program memory and mode bus: types
// assumes the cfg header gives the numeric constants
package pmmb_pkg;
    typedef enum {PMMB_MPU, PMMB_MCU, PMMB_EXT, PMMB_PROT} pmmb_mode_e;
    typedef enum {PH_ADDR, PH_TURN, PH_READ, PH_DONE} pmmb_phase_e;
endpackage : pmmb_pkg

// [verif/pmmb_ext_mem.sv]
// external program memory with its address latch, on the shared lines
// assumes the device drives adOut/adOe and pulses addrLatchStrobe once per bus cycle
`timescale 1ns/10ps
module pmmb_ext_mem #(
    parameter logic [15:0] DATA_MASK = 16'hA5C3
) (
    // clock
    input  wire logic        clk_sys,
    // device side of the shared lines
    input  wire logic [15:0] adOut,
    input  wire logic        adOe,
    input  wire logic        addrLatchStrobe,
    input  wire logic        readStrobe_n,
    // resolved lines and observation
    output logic [15:0]      adIn,
    output logic [15:0]      latchedAddr,
    output logic             busClash
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] keeper_q;
    logic        memDrive;
    // output enable follows the read strobe, as on a plain memory part
    assign memDrive = !readStrobe_n;
    // undriven lines keep their charge, so the last level stays on them
    assign adIn     = adOe ? adOut : (memDrive ? (latchedAddr ^ DATA_MASK) : keeper_q);
    assign busClash = adOe && memDrive;
    always_ff @(posedge clk_sys) begin
        keeper_q <= adIn;
    end
    always_ff @(posedge clk_sys) begin
        if (addrLatchStrobe) begin
            latchedAddr <= adIn;
        end
    end
endmodule : pmmb_ext_mem

// [verif/testbench.sv]
// self-checking bench for fetch steering, modes, vectoring and the shared bus
// assumes pmmb_core at default parameters and the external memory model beside it
`timescale 1ns/10ps
`include "pmmb_cfg.svh"
module testbench;
    localparam logic [15:0] MEM_MASK = 16'hA5C3;
    localparam logic [15:0] INT_MASK = 16'h3C3C;
    logic        clk_sys, reset_n, fetchReq, jumpReq, intReq, returnReq, dataWe;
    logic        instrValid, codeProtect, specialAccess, externalMode, busClash;
    logic        adOe, addrLatchStrobe, readStrobe_n, writeStrobe_n;
    logic [1:0]  cfgBits, intSel;
    logic [7:0]  dataAddr, dataWdata, dataRdata;
    logic [15:0] jumpAddr, progCounter, instrWord, intMemAddr, intMemData, adIn, adOut, latchedAddr;
    int          fails, testsRun;
    ////////////////////////////////////////////////////////////////////////////////
    pmmb_core dut (.clk_sys(clk_sys), .reset_n(reset_n), .cfgBits(cfgBits), .fetchReq(fetchReq),
        .jumpReq(jumpReq), .jumpAddr(jumpAddr), .intReq(intReq), .intSel(intSel), .returnReq(returnReq),
        .progCounter(progCounter), .instrWord(instrWord), .instrValid(instrValid), .codeProtect(codeProtect),
        .specialAccess(specialAccess), .externalMode(externalMode), .intMemAddr(intMemAddr),
        .intMemData(intMemData), .dataWe(dataWe), .dataAddr(dataAddr), .dataWdata(dataWdata),
        .dataRdata(dataRdata), .adIn(adIn), .adOut(adOut), .adOe(adOe), .addrLatchStrobe(addrLatchStrobe),
        .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n));
    pmmb_ext_mem #(.DATA_MASK(MEM_MASK)) mem (.clk_sys(clk_sys), .adOut(adOut), .adOe(adOe),
        .addrLatchStrobe(addrLatchStrobe), .readStrobe_n(readStrobe_n), .adIn(adIn),
        .latchedAddr(latchedAddr), .busClash(busClash));
    // on-chip program memory stand-in, combinational
    assign intMemData = intMemAddr ^ INT_MASK;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test;
        if (fails == 0 && testsRun > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk_sys);
        s = 1'b0;
        @(negedge clk_sys);
    endtask : pulse
    task automatic jump_to(input logic [15:0] a);
        jumpAddr = a;
        pulse(jumpReq);
    endtask : jump_to
    ////////////////////////////////////////////////////////////////////////////////
    // one fetch in a given mode; also writes data memory in the request cycle
    task automatic t_fetch(input logic [1:0] c, input logic [15:0] a);
        int          lat;
        int          strobes;
        int          reads;
        int          clash;
        logic        onBus;
        logic [15:0] exp;
        cfgBits = c;
        onBus = (c == `PMMB_CFG_MPU) || (c == `PMMB_CFG_EXT);
        exp = ((c == `PMMB_CFG_MPU) || (c == `PMMB_CFG_EXT && {1'b0, a} >= `PMMB_INT_WORDS)) ? a ^ MEM_MASK
            : a ^ INT_MASK;
        jump_to(a);
        fetchReq = 1'b1;
        dataWe = 1'b1;
        dataAddr = 8'h1F;
        dataWdata = a[7:0];
        @(negedge clk_sys);
        fetchReq = 1'b0;
        dataWe = 1'b0;
        lat = 1;
        strobes = 0;
        reads = 0;
        clash = 0;
        while (instrValid !== 1'b1 && lat < 12) begin
            strobes += (addrLatchStrobe === 1'b1);
            reads += (readStrobe_n === 1'b0);
            clash += (busClash !== 1'b0);
            @(negedge clk_sys);
            lat++;
        end
        chk(lat[15:0], onBus ? 16'h0004 : 16'h0001);
        chk(strobes[15:0], {15'h0000, onBus});
        chk(reads[15:0], {15'h0000, onBus});
        chk(clash[15:0], 16'h0000);
        chk({15'h0000, writeStrobe_n}, 16'h0001);
        chk(instrWord, exp);
        if (onBus) begin
            chk(latchedAddr, a);
        end
        @(negedge clk_sys);
        chk(progCounter, a + 16'h0001);
        chk({8'h00, dataRdata}, {8'h00, a[7:0]});
    endtask : t_fetch
    task automatic t_modes;
        for (int c = 0; c < 4; c++) begin
            cfgBits = c[1:0];
            jump_to(`PMMB_SPECIAL_BASE);
            chk({15'h0000, externalMode}, {15'h0000, c == 3 || c == 1});
            chk({15'h0000, codeProtect}, {15'h0000, c == 0});
            chk({15'h0000, specialAccess}, {15'h0000, c == 2 || c == 0});
            jump_to(`PMMB_SPECIAL_BASE - 16'h0001);
            chk({15'h0000, specialAccess}, 16'h0000);
        end
    endtask : t_modes
    // nested entries, then unwinding in reverse order
    task automatic t_int;
        logic [15:0] vec [4];
        vec = '{`PMMB_VEC_INT, `PMMB_VEC_TMR, `PMMB_VEC_TCK, `PMMB_VEC_PER};
        for (int i = 0; i < 4; i++) begin
            jump_to(16'h1234 + i[15:0]);
            intSel = i[1:0];
            pulse(intReq);
            chk(progCounter, vec[i]);
            intSel = (i[1:0] + 2'h1);
            pulse(intReq);
            chk(progCounter, vec[(i + 1) % 4]);
            pulse(returnReq);
            chk(progCounter, vec[i]);
            pulse(returnReq);
            chk(progCounter, 16'h1234 + i[15:0]);
        end
    endtask : t_int
    // save area writes never show on the bus
    task automatic t_data;
        int strobes;
        strobes = 0;
        cfgBits = `PMMB_CFG_MPU;
        for (int i = 0; i < 8; i++) begin
            dataAddr = `PMMB_SAVE_LO + i[7:0];
            dataWdata = 8'hC0 + i[7:0];
            dataWe = 1'b1;
            @(negedge clk_sys);
            strobes += (addrLatchStrobe !== 1'b0) + (readStrobe_n !== 1'b1);
        end
        dataWe = 1'b0;
        chk(strobes[15:0], 16'h0000);
        for (int i = 0; i < 8; i++) begin
            dataAddr = `PMMB_SAVE_LO + i[7:0];
            @(negedge clk_sys);
            chk({8'h00, dataRdata}, {8'h00, 8'hC0 + i[7:0]});
        end
    endtask : t_data
    // reset in mid-run: counter back to zero and the next fetch comes from there
    task automatic t_reset;
        cfgBits = `PMMB_CFG_MCU;
        jump_to(16'h1234);
        reset_n = 1'b0;
        @(negedge clk_sys);
        chk(progCounter, `PMMB_RESET_VEC);
        reset_n = 1'b1;
        fetchReq = 1'b1;
        @(negedge clk_sys);
        fetchReq = 1'b0;
        chk(instrWord, `PMMB_RESET_VEC ^ INT_MASK);
        @(negedge clk_sys);
        chk(progCounter, `PMMB_RESET_VEC + 16'h0001);
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #20000;
        fails++;
        finish_test();
    end
    initial begin
        {reset_n, fetchReq, jumpReq, intReq, returnReq, dataWe, intSel} = '0;
        {jumpAddr, dataAddr, dataWdata} = '0;
        cfgBits = `PMMB_CFG_UNPROG;
        fails = 0;
        testsRun = 0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        chk(progCounter, `PMMB_RESET_VEC);
        chk({15'h0000, externalMode}, 16'h0001);
        chk({14'h0000, adOe, readStrobe_n}, 16'h0001);
        t_fetch(`PMMB_CFG_MPU, 16'h0000);
        t_fetch(`PMMB_CFG_MPU, 16'hFFFF);
        t_fetch(`PMMB_CFG_MCU, 16'h0123);
        t_fetch(`PMMB_CFG_PROT, 16'h1FFF);
        t_fetch(`PMMB_CFG_EXT, 16'h1FFF);
        t_fetch(`PMMB_CFG_EXT, 16'h2000);
        t_modes();
        t_int();
        t_data();
        t_reset();
        finish_test();
    end
endmodule : testbench
